// [rtl/sac_pkg.sv]
// Behaviour
// - Qualified trigger follows the conversion trigger only while chip select is low.
// - Trigger high with chip select low starts sampling from wait, nap or conversion end.
// - Busy is high for exactly the duration of a conversion.
// - Without a sample start command at conversion end, go to wait or nap.
// - Qualified trigger low at conversion end selects nap instead of wait.
// - Nap exit needs longer acquisition; the host allows for it before converting.
// - Qualified trigger falling during a conversion aborts that conversion.
// - An aborted conversion leaves the device in wait.
// - After an abort the result word reads the fixed marker 0x3FC00.
// - Serial readout runs independently of conversion and sampling.
// - Reading during a conversion returns the previous result.
// - Chip-select framing: MSB appears on data out as chip select falls.
// - Next bit on rising clock after first falling clock; then one per rise.
// - Chip select re-lowered mid-frame restarts the frame from the MSB.
// - Frame-sync framing: MSB appears at frame sync rising edge.
// - Frame sync high at busy fall refreshes data out with the new MSB.
// - Frame sync raised mid-frame aborts the frame and starts a new one.
// - Result updates at busy fall; host starts no frame close to it.
// - Results are 18-bit two's complement, 1FFFF to 20000.
// - Conversions timed internally and finish within the maximum conversion time.
// - Serial clock only shifts data; it never touches conversion sequencing.
// - Power-down pin high tristates data out; low resumes; nap keeps driving.
// - First two conversions after power-down resume are flagged untrusted.
package sac_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int CONV_TIME_NS   = 1100;
    localparam int NAP_ENTRY_NS   = 200;
    localparam int PD_ENTRY_NS    = 10000;
    // Longest times round down, never below one cycle
    localparam int CONV_CYCLES    = (CONV_TIME_NS / CLK_PERIOD_NS) < 1 ? 1
                                    : (CONV_TIME_NS / CLK_PERIOD_NS);
    localparam int NAP_CYCLES     = (NAP_ENTRY_NS / CLK_PERIOD_NS) < 1 ? 1
                                    : (NAP_ENTRY_NS / CLK_PERIOD_NS);
    localparam int PD_CYCLES      = (PD_ENTRY_NS / CLK_PERIOD_NS) < 1 ? 1
                                    : (PD_ENTRY_NS / CLK_PERIOD_NS);

    // ----------------------------------------
    // Result word
    // ----------------------------------------
    localparam int               WORD_W       = 18;
    localparam logic [17:0]      ABORT_CODE   = 18'h3_FC00;
    localparam logic [17:0]      CODE_POS_FS  = 18'h1_FFFF;
    localparam logic [17:0]      CODE_ZERO    = 18'h0_0000;
    localparam logic [17:0]      CODE_NEG_FS  = 18'h2_0000;
    localparam logic [17:0]      RESULT_RST   = 18'h0_0000;
    localparam logic [4:0]       BIT_LAST     = 5'h1_1;
    localparam logic [4:0]       BIT_DONE     = 5'h1_2;
    localparam logic [1:0]       TRIM_CONVS   = 2'h2;
    localparam int               TMR_W        = 8;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [4:0] {
        SAC_WAIT   = 5'h0_1,
        SAC_SAMPLE = 5'h0_2,
        SAC_CONV   = 5'h0_4,
        SAC_NAP    = 5'h0_8,
        SAC_PDOWN  = 5'h1_0
    } sac_state_t;

    typedef struct packed {
        logic trig;
        logic cs_n;
        logic fs;
        logic pd;
    } sac_pins_t;

endpackage : sac_pkg

// [rtl/sac_top.sv]
`timescale 1ns/100ps
`default_nettype none

module sac_top (
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        SCLK,
    input  wire logic        CONVERSION_TRIGGER,
    input  wire logic        CS_N,
    input  wire logic        FRAME_SYNC,
    input  wire logic        POWER_DOWN_PIN,
    input  wire logic [17:0] SAMPLE_CODE,
    output logic             BUSY,
    output logic             SDO_O,
    output logic             SDO_OE_N,
    output logic             NAP_ACTIVE,
    output logic             POWERED_DOWN,
    output logic             RESULT_TRUSTED
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    sac_pkg::sac_pins_t pins_raw;
    sac_pkg::sac_pins_t pins_meta_ff;
    sac_pkg::sac_pins_t pins_ff;

    assign pins_raw.trig = CONVERSION_TRIGGER;
    assign pins_raw.cs_n = CS_N;
    assign pins_raw.fs   = FRAME_SYNC;
    assign pins_raw.pd   = POWER_DOWN_PIN;

    // Chip select and trigger idle high
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pins_meta_ff <= '{trig: 1'b1, cs_n: 1'b1, fs: 1'b1, pd: 1'b0};
            pins_ff      <= '{trig: 1'b1, cs_n: 1'b1, fs: 1'b1, pd: 1'b0};
        end else begin
            pins_meta_ff <= pins_raw;
            pins_ff      <= pins_meta_ff;
        end
    end

    // ----------------------------------------
    // Qualified trigger
    // ----------------------------------------
    logic qual_ff;
    logic qual_dly_ff;
    logic nxt_qual;
    wire  qual_fall;
    wire  start_cmd;

    assign nxt_qual  = pins_ff.cs_n ? qual_ff : pins_ff.trig;
    assign qual_fall = qual_dly_ff & ~qual_ff;
    assign start_cmd = pins_ff.trig & ~pins_ff.cs_n;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            qual_ff     <= 1'b1;
            qual_dly_ff <= 1'b1;
        end else begin
            qual_ff     <= nxt_qual;
            qual_dly_ff <= qual_ff;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    localparam logic [7:0] CONV_LAST = 8'(sac_pkg::CONV_CYCLES - 1);
    localparam logic [7:0] NAP_LAST  = 8'(sac_pkg::NAP_CYCLES - 1);
    localparam logic [7:0] PD_LAST   = 8'(sac_pkg::PD_CYCLES - 1);

    sac_pkg::sac_state_t state_ff;
    sac_pkg::sac_state_t nxt_state;
    logic [sac_pkg::TMR_W-1:0] tmr_ff;
    logic [sac_pkg::TMR_W-1:0] nxt_tmr;
    logic [17:0]         held_ff;
    logic [17:0]         result_ff;
    logic [17:0]         nxt_result;
    logic [1:0]          trim_ff;
    logic [1:0]          nxt_trim;
    logic                trusted_ff;
    logic                nxt_trusted;
    logic                settled_ff;
    logic                fs_mode_ff;

    wire conv_end  = (state_ff == sac_pkg::SAC_CONV) && (tmr_ff == CONV_LAST);
    wire do_abort  = (state_ff == sac_pkg::SAC_CONV) && qual_fall;
    wire in_save   = (state_ff == sac_pkg::SAC_NAP) || (state_ff == sac_pkg::SAC_PDOWN);
    wire save_last = (state_ff == sac_pkg::SAC_NAP) ? (tmr_ff == NAP_LAST)
                                                    : (tmr_ff == PD_LAST);

    always_comb begin
        nxt_state   = state_ff;
        nxt_tmr     = tmr_ff;
        nxt_result  = result_ff;
        nxt_trim    = trim_ff;
        nxt_trusted = trusted_ff;
        unique case (state_ff)
            sac_pkg::SAC_WAIT, sac_pkg::SAC_NAP: begin
                if (in_save && !save_last) begin
                    nxt_tmr = tmr_ff + 8'h0_1;
                end
                // Nap exit costs extra acquisition; left to the host
                if (start_cmd) begin
                    nxt_state = sac_pkg::SAC_SAMPLE;
                    nxt_tmr   = '0;
                end
            end
            sac_pkg::SAC_SAMPLE: begin
                if (qual_fall) begin
                    nxt_state = sac_pkg::SAC_CONV;
                    nxt_tmr   = '0;
                end
            end
            sac_pkg::SAC_CONV: begin
                nxt_tmr = tmr_ff + 8'h0_1;
                if (do_abort) begin
                    nxt_state  = sac_pkg::SAC_WAIT;
                    nxt_result = sac_pkg::ABORT_CODE;
                    nxt_tmr    = '0;
                end else if (conv_end) begin
                    nxt_result  = held_ff;
                    nxt_trusted = (trim_ff == 2'h0);
                    nxt_tmr     = '0;
                    if (trim_ff != 2'h0) begin
                        nxt_trim = trim_ff - 2'h1;
                    end
                    if (start_cmd) begin
                        nxt_state = sac_pkg::SAC_SAMPLE;
                    end else if (!qual_ff) begin
                        nxt_state = sac_pkg::SAC_NAP;
                    end else begin
                        nxt_state = sac_pkg::SAC_WAIT;
                    end
                end
            end
            sac_pkg::SAC_PDOWN: begin
                if (!save_last) begin
                    nxt_tmr = tmr_ff + 8'h0_1;
                end
                if (!pins_ff.pd) begin
                    nxt_state   = sac_pkg::SAC_WAIT;
                    nxt_tmr     = '0;
                    nxt_trim    = sac_pkg::TRIM_CONVS;
                    nxt_trusted = 1'b0;
                end
            end
            default: begin
                nxt_state = sac_pkg::SAC_WAIT;
                nxt_tmr   = '0;
            end
        endcase
        // Power-down pin overrides any phase, conversion included
        if (pins_ff.pd && state_ff != sac_pkg::SAC_PDOWN) begin
            nxt_state = sac_pkg::SAC_PDOWN;
            nxt_tmr   = '0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff   <= sac_pkg::SAC_WAIT;
            tmr_ff     <= '0;
            result_ff  <= sac_pkg::RESULT_RST;
            trim_ff    <= 2'h0;
            trusted_ff <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            tmr_ff     <= nxt_tmr;
            result_ff  <= nxt_result;
            trim_ff    <= nxt_trim;
            trusted_ff <= nxt_trusted;
        end
    end

    // ----------------------------------------
    // Sample hold and status
    // ----------------------------------------
    // Input frozen as the conversion starts, as a hold capacitor would
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            held_ff <= sac_pkg::RESULT_RST;
        end else if (state_ff == sac_pkg::SAC_SAMPLE && qual_fall) begin
            held_ff <= SAMPLE_CODE;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            settled_ff <= 1'b0;
        end else begin
            // Dropped on any state change, so nap settling never shows as power-down
            settled_ff <= in_save && save_last && (nxt_state == state_ff);
        end
    end

    // Sticky once frame sync is seen low; a tied-high pin keeps chip-select framing
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fs_mode_ff <= 1'b0;
        end else if (!pins_ff.fs) begin
            fs_mode_ff <= 1'b1;
        end
    end

    assign BUSY           = state_ff[2];
    assign NAP_ACTIVE     = settled_ff & state_ff[3];
    assign POWERED_DOWN   = settled_ff & state_ff[4];
    assign RESULT_TRUSTED = trusted_ff;

    // ----------------------------------------
    // Serial link, on SCLK
    // ----------------------------------------
    // Frame held at MSB while chip select is high or frame sync is high in
    // frame-sync mode; clearing asynchronously puts the MSB out without a clock
    logic       fell_ff;
    logic [4:0] bit_idx_ff;
    wire        ser_clr;
    wire        bit_out;
    wire [4:0]  bit_pos;

    assign ser_clr = ~ARST_N | CS_N | (FRAME_SYNC & fs_mode_ff)
                     | state_ff[4];

    always_ff @(negedge SCLK or posedge ser_clr) begin
        if (ser_clr) begin
            fell_ff <= 1'b0;
        end else begin
            fell_ff <= 1'b1;
        end
    end

    always_ff @(posedge SCLK or posedge ser_clr) begin
        if (ser_clr) begin
            bit_idx_ff <= 5'h0_0;
        end else if (fell_ff && bit_idx_ff != sac_pkg::BIT_DONE) begin
            bit_idx_ff <= bit_idx_ff + 5'h0_1;
        end
    end

    // Result word only changes at busy fall, which the host keeps clear of
    assign bit_pos = sac_pkg::BIT_LAST - bit_idx_ff;
    assign bit_out = (bit_idx_ff == sac_pkg::BIT_DONE) ? 1'b0
                     : result_ff[bit_pos];

    // Index zero shows the MSB, refreshed by a new result while held
    assign SDO_O    = bit_out;
    assign SDO_OE_N = CS_N | state_ff[4];

endmodule : sac_top

`default_nettype wire

// [tb/sac_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

module sac_host_model (
    input  wire logic        en,
    input  wire logic        sdo,
    output logic             sclk,
    output logic [23:0]      word,
    output logic             done
);
    // Clock idles low, so the first edge of a frame is a rise that must not shift
    initial begin
        sclk = 1'b0;
        word = 24'h00_0000;
        done = 1'b0;
        forever begin
            wait (en);
            done = 1'b0;
            repeat (24) begin
                #62.5 sclk = 1'b1;
                #62.5 sclk = 1'b0;
                word = {word[22:0], sdo};
            end
            done = 1'b1;
            wait (!en);
        end
    end
endmodule : sac_host_model

`default_nettype wire

// [tb/sac_monitor.sv]
`timescale 1ns/100ps
`default_nettype none

module sac_monitor (
    input  wire logic CLK,
    input  wire logic ARST_N,
    input  wire logic CONVERSION_TRIGGER,
    input  wire logic CS_N,
    input  wire logic POWER_DOWN_PIN,
    input  wire logic BUSY,
    input  wire logic SDO_OE_N,
    input  wire logic NAP_ACTIVE,
    input  wire logic POWERED_DOWN,
    input  wire logic RESULT_TRUSTED
);
    // ----------------------------------------
    // Sequencing and pin checks
    // ----------------------------------------
    default clocking mc @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    busy_bound_a: assert property ($rose(BUSY) |-> ##[1:22] !BUSY)
        else $error("Conversion ran past its time");
    busy_cause_a: assert property ($rose(BUSY) |-> !$past(CONVERSION_TRIGGER, 3))
        else $error("Busy rose without a trigger fall");
    cs_gate_a: assert property (CS_N [*6] |=> !$rose(BUSY))
        else $error("Conversion started while deselected");
    cs_tristate_a: assert property (CS_N |-> SDO_OE_N)
        else $error("Data out driven while deselected");
    pd_tristate_a: assert property (POWERED_DOWN |-> SDO_OE_N)
        else $error("Data out driven in power-down");
    pd_idle_a: assert property (POWERED_DOWN |-> !BUSY && !NAP_ACTIVE)
        else $error("Activity during power-down");
    pd_entry_a: assert property ($rose(POWERED_DOWN) |-> $past(POWER_DOWN_PIN, 8))
        else $error("Power-down without the pin");
    nap_idle_a: assert property (NAP_ACTIVE |-> !BUSY)
        else $error("Nap during a conversion");
    nap_entry_a: assert property ($rose(NAP_ACTIVE) |-> !$past(BUSY, 4))
        else $error("Nap entered too soon after busy");
    trust_rise_a: assert property ($rose(RESULT_TRUSTED) |-> $fell(BUSY))
        else $error("Trust set away from a result");
endmodule : sac_monitor

bind sac_top sac_monitor sac_monitor_i (.CLK(CLK), .ARST_N(ARST_N),
    .CONVERSION_TRIGGER(CONVERSION_TRIGGER), .CS_N(CS_N), .POWER_DOWN_PIN(POWER_DOWN_PIN),
    .BUSY(BUSY), .SDO_OE_N(SDO_OE_N), .NAP_ACTIVE(NAP_ACTIVE),
    .POWERED_DOWN(POWERED_DOWN), .RESULT_TRUSTED(RESULT_TRUSTED));

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic               clk, arst_n, sclk, en, done;
    logic               busy, sdo, oe_n, nap, pdn, trusted;
    logic [17:0]        code;
    logic [23:0]        word;
    sac_pkg::sac_pins_t pin;
    int                 fails, checks_done;
    // No pull on the data line: a released line reads inverted
    wire                sdo_bus = oe_n ? ~sdo : sdo;

    sac_top sac_top_i (.CLK(clk), .ARST_N(arst_n), .SCLK(sclk),
        .CONVERSION_TRIGGER(pin.trig), .CS_N(pin.cs_n), .FRAME_SYNC(pin.fs),
        .POWER_DOWN_PIN(pin.pd), .SAMPLE_CODE(code), .BUSY(busy), .SDO_O(sdo),
        .SDO_OE_N(oe_n), .NAP_ACTIVE(nap), .POWERED_DOWN(pdn), .RESULT_TRUSTED(trusted));
    sac_host_model sac_host_model_i (.en(en), .sdo(sdo_bus), .sclk(sclk), .word(word), .done(done));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic conv(input logic [17:0] c, input logic hold, input logic abt, output int n);
        @(posedge clk);
        code <= c;
        pin.trig <= 1'b1;
        pin.cs_n <= 1'b0;
        repeat (12) @(posedge clk);
        pin.trig <= 1'b0;
        n = 0;
        repeat (10) if (!busy) @(negedge clk);
        while (busy && n < 40) begin
            n++;
            @(posedge clk);
            pin.trig <= hold | (abt && n >= 8 && n < 12);
            @(negedge clk);
        end
        repeat (12) @(negedge clk);
    endtask : conv

    task automatic rd(input logic [17:0] e, input logic fsm);
        @(posedge clk);
        if (fsm) pin.fs <= 1'b1; else pin.cs_n <= 1'b1;
        @(posedge clk);
        if (fsm) pin.fs <= 1'b0; else pin.cs_n <= 1'b0;
        en <= 1'b1;
        @(negedge clk);
        chk({22'h0, oe_n, sdo}, {22'h0, 1'b0, e[17]});
        repeat (100) if (!done) @(negedge clk);
        chk(word, {e, 6'h00});
        @(posedge clk);
        en <= 1'b0;
    endtask : rd

    task automatic t_cut(input logic [17:0] e, input logic fsm);
        @(posedge clk);
        if (fsm) pin.fs <= 1'b1; else pin.cs_n <= 1'b1;
        @(posedge clk);
        if (fsm) pin.fs <= 1'b0; else pin.cs_n <= 1'b0;
        en <= 1'b1;
        // Eight link clocks in, the frame sits on bit 10
        repeat (19) @(posedge clk);
        @(negedge clk);
        chk({23'h0, sdo}, {23'h0, e[10]});
        @(posedge clk);
        if (fsm) pin.fs <= 1'b1; else pin.cs_n <= 1'b1;
        @(posedge clk);
        if (fsm) pin.fs <= 1'b0; else pin.cs_n <= 1'b0;
        @(negedge clk);
        chk({23'h0, sdo}, {23'h0, e[17]});
        repeat (100) if (!done) @(negedge clk);
        @(posedge clk);
        en <= 1'b0;
    endtask : t_cut

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_nap;
        int n;
        conv(18'h1_FFFF, 1'b0, 1'b0, n);
        chk(24'(n), 24'h00_0016);
        chk({23'h0, nap}, 24'h00_0001);
        rd(18'h1_FFFF, 1'b0);
        t_cut(18'h1_FFFF, 1'b0);
    endtask : t_nap

    task automatic t_b2b;
        int n;
        conv(18'h2_0000, 1'b1, 1'b0, n);
        chk({23'h0, nap}, 24'h00_0000);
        @(posedge clk);
        code <= 18'h0_0000;
        pin.trig <= 1'b0;
        repeat (10) if (!busy) @(negedge clk);
        @(posedge clk) pin.cs_n <= 1'b1;
        @(posedge clk) pin.cs_n <= 1'b0;
        @(negedge clk);
        chk({22'h0, busy, sdo}, 24'h00_0003);
        repeat (40) if (busy) @(negedge clk);
        rd(18'h0_0000, 1'b0);
    endtask : t_b2b

    task automatic t_abort;
        int n;
        conv(18'h1_2345, 1'b0, 1'b1, n);
        chk({23'h0, n < 22}, 24'h00_0001);
        chk({23'h0, nap}, 24'h00_0000);
        rd(18'h3_FC00, 1'b0);
    endtask : t_abort

    task automatic t_fs;
        int n;
        @(posedge clk) pin.fs <= 1'b0;
        repeat (4) @(posedge clk);
        pin.fs <= 1'b1;
        @(negedge clk);
        chk({23'h0, sdo}, 24'h00_0001);
        conv(18'h1_FFFF, 1'b0, 1'b0, n);
        chk({23'h0, sdo}, 24'h00_0000);
        rd(18'h1_FFFF, 1'b1);
        t_cut(18'h1_FFFF, 1'b1);
    endtask : t_fs

    task automatic t_pd;
        int n;
        @(posedge clk) pin.pd <= 1'b1;
        repeat (300) if (!pdn) @(negedge clk);
        chk({22'h0, pdn, oe_n}, 24'h00_0003);
        @(posedge clk) pin.pd <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            conv(18'h0_1111, 1'b0, 1'b0, n);
            chk({23'h0, trusted}, {23'h0, i == 2});
        end
    endtask : t_pd

    task automatic wrap_up;
        if (fails == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Generous bound: the whole sequence needs just under a tenth of this
    initial begin
        #500000;
        fails++;
        wrap_up();
    end

    initial begin
        arst_n = 1'b0;
        en = 1'b0;
        code = 18'h0_0000;
        fails = 0;
        checks_done = 0;
        pin = '{1'b0, 1'b1, 1'b1, 1'b0};
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_nap();
        t_b2b();
        t_abort();
        t_fs();
        t_pd();
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
